// *** pop_consts.svh ***
// Register offsets, field positions, reset values and constants of the pixel output path
`ifndef POP_CONSTS_SVH
`define POP_CONSTS_SVH
`define POP_ADDR_CTRL 16'h301a
`define POP_ADDR_TIMING 16'h31c0
`define POP_CTRL_RESET 16'h0000
`define POP_CTRL_WMASK 16'h1fff
`define POP_TIMING_RESET 16'h0000
`define POP_TIMING_WMASK 16'h7fff
`define POP_CTRL_PAR_EN 0
`define POP_CTRL_SER_EN 1
`define POP_CTRL_PROTO_LSB 2
`define POP_CTRL_LANES_LSB 4
`define POP_CTRL_WSEL_LSB 6
`define POP_CTRL_CMP_EN 9
`define POP_CTRL_CMP14 10
`define POP_CTRL_HDR 11
`define POP_CTRL_ALAW 12
`define POP_CTRL_STAT_LOCK 13
`define POP_CTRL_STAT_BUSY 14
`define POP_DLY_BITS 3
`define POP_DLY_ALL 15
`define POP_LINE_WORDS 12'd2200
`define POP_FILL_CODE 20'h00001
`define POP_K16_A 17'h00400
`define POP_K16_B 17'h01000
`define POP_K16_C 17'h04000
`define POP_K12_B 17'h00700
`define POP_K12_C 17'h00a00
`define POP_K14_B 17'h02800
`define POP_KAL_A 17'h00100
`define POP_KAL_B 17'h00400
`define POP_KAL_AB 17'h001c0
`endif

// *** pop_pkg.sv ***
// Types shared by the pixel output path
package pop_pkg;
	typedef enum logic [1:0] {
		POP_PROTO_STREAM = 2'b00,
		POP_PROTO_CONT = 2'b01,
		POP_PROTO_ACTIVE = 2'b10
	} pop_proto_t;
	typedef enum logic [1:0] {
		POP_LANES_1 = 2'b00,
		POP_LANES_2 = 2'b01,
		POP_LANES_4 = 2'b10
	} pop_lanes_t;
	typedef enum logic [2:0] {
		POP_W10 = 3'b000,
		POP_W12 = 3'b001,
		POP_W14 = 3'b010,
		POP_W16 = 3'b011,
		POP_W20 = 3'b100
	} pop_wsel_t;
endpackage : pop_pkg

// *** pop_sync2.sv ***
// Two-flop level synchroniser with synchronous clear
`timescale 1ns/1ps
`include "pop_consts.svh"
module pop_sync2 #(
	parameter int W = 1
) (
	// Destination clock and clear
	input wire logic clk,
	input wire logic rstn,
	// Level in and synchronised level out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (!rstn) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : pop_sync2

// *** pop_compander.sv ***
// Bit depth reduction: HDR companding to 12 or 14 bits, linear A-law to 10 bits
`timescale 1ns/1ps
`include "pop_consts.svh"
module pop_compander (
	// Mode
	input wire logic hdrMode,
	input wire logic compEn,
	input wire logic comp14,
	input wire logic alawEn,
	// Pixel in and code out
	input wire logic [15:0] pixIn,
	output logic [15:0] codeOut
);
	logic [16:0] v;
	logic [16:0] r;

	// Piecewise linear knees keep codes monotonic and gapless
	always_comb begin
		v = {1'b0, pixIn};
		r = v;
		if (hdrMode && compEn && !comp14) begin
			if (v < `POP_K16_A)
				r = v;
			else if (v < `POP_K16_B)
				r = `POP_K16_A + ((v - `POP_K16_A) >> 2);
			else if (v < `POP_K16_C)
				r = `POP_K12_B + ((v - `POP_K16_B) >> 4);
			else
				r = `POP_K12_C + ((v - `POP_K16_C) >> 5);
		end else if (hdrMode && compEn) begin
			if (v < `POP_K16_B)
				r = v;
			else if (v < `POP_K16_C)
				r = `POP_K16_B + ((v - `POP_K16_B) >> 1);
			else
				r = `POP_K14_B + ((v - `POP_K16_C) >> 3);
		end else if (!hdrMode && alawEn) begin
			if (v < `POP_KAL_A)
				r = v;
			else if (v < `POP_KAL_B)
				r = `POP_KAL_A + ((v - `POP_KAL_A) >> 2);
			else
				r = `POP_KAL_AB + ((v - `POP_KAL_B) >> 3);
		end else if (!hdrMode) begin
			r = {5'h00, v[11:0]}; // Linear pixels are 12 bits
		end
		codeOut = r[15:0];
	end
endmodule : pop_compander

// *** pop_output_path.sv ***
// Pixel output path: register port, parallel pixel bus and four-lane serial link
// Overview of operation
// - Parallel port drives only frame qualifier, row qualifier, pixel clock, 12-bit data.
// - Parallel port stays idle after reset until software sets its control enable.
// - Continuous serial formats send every line, active or blanking, at one length.
// - Active-only serial format sends pixel words only, nothing during blanking.
// - Serial link is one-way, four data lanes sharing one DDR clock lane.
// - Serial words are 10, 12, 14, 16 or 20 bits on 1, 2 or 4 lanes.
// - After delay loop lock, each lane delays independently in eighth-UI steps.
// - Clock and data lane delay codes live in the serial timing register.
// - Companding turns each 16-bit HDR pixel into a 12- or 14-bit code.
// - Linear mode may A-law 12-bit pixels to 10 bits; off after reset.
// - Data and qualifiers change at pixel clock fall; receiver samples at rise.
`timescale 1ns/1ps
`include "pop_consts.svh"
module pop_output_path
	import pop_pkg::*;
(
	// System clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register port
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWrData,
	output logic [15:0] regRdData,
	output logic regRdValid,
	// Pixel stream from the image pipe
	input wire logic inValid,
	input wire logic [15:0] inData,
	input wire logic inFrame,
	input wire logic inRow,
	output logic inReady,
	// Parallel pixel port
	output logic pixClkOut,
	output logic frame_qual_out,
	output logic row_qual_out,
	output logic [11:0] pixDataOut,
	// Delay loop lock pin and lane delay codes
	input wire logic dllLocked,
	output logic [14:0] laneDelayCode,
	// Serial link clock and lanes
	input wire logic linkClk,
	output logic clkLaneOn,
	output logic [3:0] laneOn,
	output logic [3:0] laneRise,
	output logic [3:0] laneFall,
	output logic lineMark
);
	// Control and timing registers
	logic [15:0] ctrl_q;
	logic [15:0] timing_q;
	logic parEn;
	logic serEn;
	logic hdrMode;
	logic lockS;
	logic serPend;

	assign parEn = ctrl_q[`POP_CTRL_PAR_EN];
	assign serEn = ctrl_q[`POP_CTRL_SER_EN];
	assign hdrMode = ctrl_q[`POP_CTRL_HDR];

	// Register writes; enables and A-law clear at reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrl_q <= `POP_CTRL_RESET;
		end else if (regWrEn && regAddr == `POP_ADDR_CTRL) begin
			ctrl_q <= regWrData & `POP_CTRL_WMASK;
		end
	end

	// Lane delay codes, clock lane in the low field
	always_ff @(posedge clk) begin
		if (!resetn) begin
			timing_q <= `POP_TIMING_RESET;
		end else if (regWrEn && regAddr == `POP_ADDR_TIMING) begin
			timing_q <= regWrData & `POP_TIMING_WMASK;
		end
	end

	// Reads; status bits show lock and an unfinished serial handoff
	always_ff @(posedge clk) begin
		if (!resetn) begin
			regRdData <= 16'h0000;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regRdEn;
			if (!regRdEn)
				regRdData <= 16'h0000;
			else if (regAddr == `POP_ADDR_CTRL) begin
				regRdData <= ctrl_q;
				regRdData[`POP_CTRL_STAT_LOCK] <= lockS;
				regRdData[`POP_CTRL_STAT_BUSY] <= serPend;
			end else if (regAddr == `POP_ADDR_TIMING)
				regRdData <= timing_q;
			else
				regRdData <= 16'h0000; // Unmapped reads return zero
		end
	end

	// Lock pin comes from the analog delay loop, outside this clock
	pop_sync2 #(.W(1)) uLockSync (
		.clk(clk),
		.rstn(resetn),
		.d(dllLocked),
		.q(lockS)
	);

	// Codes are withheld until lock, since steps mean nothing before it
	always_ff @(posedge clk) begin
		if (!resetn)
			laneDelayCode <= 15'h0000;
		else if (lockS)
			laneDelayCode <= timing_q[`POP_DLY_ALL-1:0];
		else
			laneDelayCode <= 15'h0000;
	end

	// Bit depth reduction
	logic [15:0] code;

	pop_compander uComp (
		.hdrMode(hdrMode),
		.compEn(ctrl_q[`POP_CTRL_CMP_EN]),
		.comp14(ctrl_q[`POP_CTRL_CMP14]),
		.alawEn(ctrl_q[`POP_CTRL_ALAW]),
		.pixIn(inData),
		.codeOut(code)
	);

	// Fit the code onto the 12-bit bus
	logic [11:0] parWord;

	always_comb begin
		if (hdrMode && !ctrl_q[`POP_CTRL_CMP_EN])
			parWord = code[15:4];
		else if (hdrMode && ctrl_q[`POP_CTRL_CMP14])
			parWord = code[13:2];
		else
			parWord = code[11:0];
	end

	// Pixel clock is clk/2; with the parallel port on, a word is taken only in the cycle before its fall
	logic phase_q;
	logic take;
	logic serBlock;
	logic inReady_d;

	assign take = inValid && inReady;
	assign serBlock = serEn && (take || serPend);

	always_comb begin
		inReady_d = (parEn || serEn) && !serBlock;
		if (parEn && phase_q)
			inReady_d = 1'b0;
	end

	// Ready is registered so the source sees it one cycle ahead
	always_ff @(posedge clk) begin
		if (!resetn) begin
			phase_q <= 1'b0;
			inReady <= 1'b0;
		end else begin
			phase_q <= ~phase_q;
			inReady <= inReady_d;
		end
	end

	// Parallel outputs launch together with the falling pixel clock edge
	always_ff @(posedge clk) begin
		if (!resetn || !parEn) begin
			pixClkOut <= 1'b0;
			frame_qual_out <= 1'b0;
			row_qual_out <= 1'b0;
			pixDataOut <= 12'h000;
		end else begin
			pixClkOut <= ~phase_q;
			if (phase_q) begin
				frame_qual_out <= inFrame;
				row_qual_out <= take && inRow && inFrame;
				pixDataOut <= (take && inRow && inFrame) ? parWord : 12'h000;
			end
		end
	end

	// Serial word width and handoff to the link domain
	logic [19:0] serWord_q;
	logic reqTgl_q;
	logic ackS;
	logic [19:0] wordMask;

	always_comb begin
		case (pop_wsel_t'(ctrl_q[`POP_CTRL_WSEL_LSB +: 3]))
			POP_W10: wordMask = 20'h003ff;
			POP_W12: wordMask = 20'h00fff;
			POP_W14: wordMask = 20'h03fff;
			POP_W16: wordMask = 20'h0ffff;
			default: wordMask = 20'hfffff;
		endcase
	end

	assign serPend = reqTgl_q != ackS;

	// Word holds still while its request is outstanding, so it crosses safely
	always_ff @(posedge clk) begin
		if (!resetn) begin
			serWord_q <= 20'h00000;
			reqTgl_q <= 1'b0;
		end else if (take && serEn && inFrame && inRow) begin
			serWord_q <= {4'h0, code} & wordMask;
			reqTgl_q <= ~reqTgl_q;
		end
	end

	// Link domain reset, config and request crossings
	logic lkRstn;
	logic reqS;
	logic [7:0] cfgS;
	logic ackTgl_q;

	pop_sync2 #(.W(1)) uRstSync (
		.clk(linkClk),
		.rstn(1'b1),
		.d(resetn),
		.q(lkRstn)
	);

	pop_sync2 #(.W(1)) uReqSync (
		.clk(linkClk),
		.rstn(lkRstn),
		.d(reqTgl_q),
		.q(reqS)
	);

	pop_sync2 #(.W(8)) uCfgSync (
		.clk(linkClk),
		.rstn(lkRstn),
		.d(ctrl_q[`POP_CTRL_SER_EN +: 8]),
		.q(cfgS)
	);

	pop_sync2 #(.W(1)) uAckSync (
		.clk(clk),
		.rstn(resetn),
		.d(ackTgl_q),
		.q(ackS)
	);

	// Config fields as seen on the link clock
	logic lkSerEn;
	pop_proto_t lkProto;
	pop_lanes_t lkLanes;
	logic [4:0] step;
	logic [4:0] width;

	// Config bits may resolve in different link cycles; take them once two samples agree
	logic [7:0] cfgPrev_q;
	logic [7:0] cfg_q;

	always_ff @(posedge linkClk) begin
		if (!lkRstn) begin
			cfgPrev_q <= 8'h00;
			cfg_q <= 8'h00;
		end else begin
			cfgPrev_q <= cfgS;
			if (cfgS == cfgPrev_q)
				cfg_q <= cfgS;
		end
	end

	assign lkSerEn = cfg_q[0];
	assign lkProto = pop_proto_t'(cfg_q[2:1]);
	assign lkLanes = pop_lanes_t'(cfg_q[4:3]);

	// Two bits per active lane per link cycle, one on each clock edge
	always_comb begin
		case (lkLanes)
			POP_LANES_1: step = 5'd2;
			POP_LANES_2: step = 5'd4;
			default: step = 5'd8;
		endcase
		case (pop_wsel_t'(cfg_q[7:5]))
			POP_W10: width = 5'd10;
			POP_W12: width = 5'd12;
			POP_W14: width = 5'd14;
			POP_W16: width = 5'd16;
			default: width = 5'd20;
		endcase
	end

	// Serialiser state on the link clock
	logic [19:0] shift_q;
	logic [4:0] left_q;
	logic reqSeen_q;
	logic [11:0] slot_q;
	logic newWord;
	logic lastSlot;

	assign newWord = reqS != reqSeen_q;
	assign lastSlot = slot_q == `POP_LINE_WORDS - 12'd1;

	// Continuous formats fill idle slots so each line has the same word count
	always_ff @(posedge linkClk) begin
		if (!lkRstn) begin
			shift_q <= 20'h00000;
			left_q <= 5'd0;
			reqSeen_q <= 1'b0;
			ackTgl_q <= 1'b0;
			slot_q <= 12'd0;
			lineMark <= 1'b0;
		end else if (left_q > step) begin
			shift_q <= shift_q >> step;
			left_q <= left_q - step;
			lineMark <= 1'b0;
		end else if (lkSerEn && newWord) begin
			shift_q <= serWord_q;
			left_q <= width;
			reqSeen_q <= reqS;
			ackTgl_q <= ~ackTgl_q;
			slot_q <= lastSlot ? 12'd0 : slot_q + 12'd1;
			lineMark <= slot_q == 12'd0;
		end else if (lkSerEn && lkProto != POP_PROTO_ACTIVE) begin
			shift_q <= `POP_FILL_CODE;
			left_q <= width;
			slot_q <= lastSlot ? 12'd0 : slot_q + 12'd1;
			lineMark <= slot_q == 12'd0;
		end else begin
			left_q <= 5'd0;
			lineMark <= 1'b0;
		end
	end

	// Lane drivers; unused lanes stay quiet
	always_ff @(posedge linkClk) begin
		if (!lkRstn) begin
			laneRise <= 4'h0;
			laneFall <= 4'h0;
			laneOn <= 4'h0;
			clkLaneOn <= 1'b0;
		end else begin
			clkLaneOn <= lkSerEn;
			for (int i = 0; i < 4; i++) begin
				// Lanes stop with the clock lane, even in mid-word
				if (lkSerEn && left_q != 5'd0 && 5'(2 * i) < step) begin
					laneRise[i] <= shift_q[2 * i];
					laneFall[i] <= shift_q[2 * i + 1];
					laneOn[i] <= 1'b1;
				end else begin
					laneRise[i] <= 1'b0;
					laneFall[i] <= 1'b0;
					laneOn[i] <= 1'b0;
				end
			end
		end
	end
endmodule : pop_output_path

// *** pop_output_path_checker.sv ***
// Port assertions for the pixel output path
`timescale 1ns/1ps
module pop_output_path_checker (
	// Clocks and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic linkClk,
	// Register port
	input wire logic regRdEn,
	input wire logic [15:0] regRdData,
	input wire logic regRdValid,
	// Pixel stream and parallel port
	input wire logic inValid,
	input wire logic inReady,
	input wire logic pixClkOut,
	input wire logic frame_qual_out,
	input wire logic row_qual_out,
	input wire logic [11:0] pixDataOut,
	// Delay loop and serial link
	input wire logic dllLocked,
	input wire logic [14:0] laneDelayCode,
	input wire logic clkLaneOn,
	input wire logic [3:0] laneOn,
	input wire logic lineMark
);
	a_par_reset_idle: assert property (@(posedge clk) disable iff (!resetn)
		$past(!resetn) |-> !pixClkOut && !row_qual_out && !inReady)
		else $error("parallel port active right after reset");
	a_data_gated: assert property (@(posedge clk) disable iff (!resetn)
		!row_qual_out |-> pixDataOut == 12'h000) else $error("data outside row");
	a_row_in_frame: assert property (@(posedge clk) disable iff (!resetn)
		row_qual_out |-> frame_qual_out) else $error("row qualifier outside frame");
	a_launch_on_fall: assert property (@(posedge clk) disable iff (!resetn)
		$changed(pixDataOut) || $rose(row_qual_out) |-> !pixClkOut)
		else $error("launch not at pixel clock fall");
	a_pixclk_half: assert property (@(posedge clk) disable iff (!resetn)
		$rose(pixClkOut) |=> $fell(pixClkOut)) else $error("pixel clock high too long");
	a_take_pace: assert property (@(posedge clk) disable iff (!resetn)
		inValid && inReady |=> !inReady) else $error("pixels taken back to back");
	a_read_idle_zero: assert property (@(posedge clk) disable iff (!resetn)
		!regRdEn |=> !regRdValid && regRdData == 16'h0000) else $error("stray read data");
	a_delay_unlocked: assert property (@(posedge clk) disable iff (!resetn)
		!dllLocked [*4] |-> laneDelayCode == 15'h0000) else $error("delay without lock");
	a_lanes_need_clk: assert property (@(posedge linkClk) disable iff (!resetn)
		!clkLaneOn |-> laneOn == 4'h0) else $error("lanes run without clock lane");
	a_mark_pulse: assert property (@(posedge linkClk) disable iff (!resetn)
		lineMark |=> !lineMark) else $error("line mark longer than one cycle");
endmodule : pop_output_path_checker

bind pop_output_path pop_output_path_checker chk (.clk, .resetn, .linkClk, .regRdEn,
	.regRdData, .regRdValid, .inValid, .inReady, .pixClkOut, .frame_qual_out,
	.row_qual_out, .pixDataOut, .dllLocked, .laneDelayCode, .clkLaneOn, .laneOn, .lineMark);

// *** pop_rx_model.sv ***
// Receiver model: captures the parallel bus and rebuilds serial words
`timescale 1ns/1ps
module pop_rx_model (
	// Bench clear
	input wire logic clr,
	// Parallel port
	input wire logic pixClkOut,
	input wire logic frame_qual_out,
	input wire logic row_qual_out,
	input wire logic [11:0] pixDataOut,
	// Serial link, listened to only
	input wire logic linkClk,
	input wire logic [3:0] laneOn,
	input wire logic [3:0] laneRise,
	input wire logic [3:0] laneFall,
	input wire logic lineMark,
	// What was received
	output logic [11:0] rxWord,
	output logic [7:0] rxCount,
	output logic [15:0] serWord,
	output logic [15:0] lineGap,
	output logic [7:0] markCount
);
	int sh;
	logic [15:0] gapCnt;
	// Sample at the rising pixel clock, only with both qualifiers high
	always @(posedge pixClkOut or posedge clr) begin
		if (clr) begin
			rxWord <= 12'h000;
			rxCount <= 8'h00;
		end else if (frame_qual_out && row_qual_out) begin
			rxWord <= pixDataOut;
			rxCount <= rxCount + 8'h01;
		end
	end
	// First 16 link bits, low bits first; never drives anything back
	always @(posedge linkClk or posedge clr) begin
		if (clr) begin
			sh = 0;
			serWord <= 16'h0000;
			gapCnt <= 16'h0000;
			lineGap <= 16'h0000;
			markCount <= 8'h00;
		end else begin
			if (laneOn != 4'h0 && sh < 16) begin
				for (int i = 0; i < 4; i++) begin
					serWord[sh + 2 * i] <= laneRise[i];
					serWord[sh + 2 * i + 1] <= laneFall[i];
				end
				sh = sh + 8;
			end
			gapCnt <= lineMark ? 16'h0001 : gapCnt + 16'h0001;
			if (lineMark) begin
				lineGap <= gapCnt;
				markCount <= markCount + 8'h01;
			end
		end
	end
endmodule : pop_rx_model

// *** tb_top.sv ***
// Self-checking bench for the pixel output path
`timescale 1ns/1ps
`include "pop_consts.svh"
module tb_top;
	typedef struct {logic [15:0] a; logic [15:0] w; logic [15:0] e;} pop_row_t;
	logic clk = 0, linkClk = 0, resetn = 0, clr = 0, dllLocked = 0;
	logic regWrEn = 0, regRdEn = 0, inValid = 0, inFrame = 0, inRow = 0;
	logic [15:0] regAddr = 0, regWrData = 0, inData = 0, rd;
	logic [15:0] regRdData, serWord, lineGap;
	logic regRdValid, inReady, pixClkOut, frame_qual_out, row_qual_out, clkLaneOn, lineMark;
	logic [11:0] pixDataOut, rxWord;
	logic [14:0] laneDelayCode;
	logic [3:0] laneOn, laneRise, laneFall;
	logic [7:0] rxCount, markCount;
	int failures = 0, checks = 0;
	pop_row_t rows [4] = '{'{16'h301a, 16'he000, 16'h0000}, '{16'h31c0, 16'hffff, 16'h7fff},
		'{16'h1234, 16'hffff, 16'h0000}, '{16'h301a, 16'h0001, 16'h0001}};
	// Parallel cases: control value, pixel in, word the receiver should see
	pop_row_t pix [9] = '{'{16'h0001, 16'h05a5, 16'h05a5}, '{16'h0001, 16'h0fff, 16'h0fff},
		'{16'h0001, 16'h0000, 16'h0000}, '{16'h0001, 16'h0123, 16'h0123},
		'{16'h0a01, 16'hffff, 16'h0fff}, '{16'h0a01, 16'h0200, 16'h0200},
		'{16'h0e01, 16'hffff, 16'h0fff}, '{16'h0801, 16'habcd, 16'h0abc},
		'{16'h1001, 16'h0fff, 16'h033f}};
	pop_output_path dut (.clk, .resetn, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
		.regRdValid, .inValid, .inData, .inFrame, .inRow, .inReady, .pixClkOut, .frame_qual_out,
		.row_qual_out, .pixDataOut, .dllLocked, .laneDelayCode, .linkClk, .clkLaneOn, .laneOn,
		.laneRise, .laneFall, .lineMark);
	pop_rx_model rx (.clr, .pixClkOut, .frame_qual_out, .row_qual_out, .pixDataOut, .linkClk,
		.laneOn, .laneRise, .laneFall, .lineMark, .rxWord, .rxCount, .serWord, .lineGap,
		.markCount);
	// Clocks with unrelated phase
	initial forever #12.5 clk = ~clk;
	initial begin
		#3.7;
		forever #7.5 linkClk = ~linkClk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		regWrEn = 1;
		regAddr = a;
		regWrData = d;
		@(negedge clk);
		regWrEn = 0;
	endtask : reg_wr
	// Read data stands one cycle, so it is taken at the next falling edge
	task automatic reg_rd(input logic [15:0] a, output logic [15:0] d);
		@(negedge clk);
		regRdEn = 1;
		regAddr = a;
		@(negedge clk);
		d = regRdData;
		check(16'(regRdValid), 16'h0001);
		regRdEn = 0;
	endtask : reg_rd
	task automatic send_pix(input logic [15:0] v);
		@(negedge clk);
		inValid = 1;
		inData = v;
		inFrame = 1;
		inRow = 1;
		for (int n = 0; n < 60 && inReady !== 1'b1; n++) @(negedge clk);
		@(negedge clk);
		inValid = 0;
		inRow = 0;
	endtask : send_pix
	task automatic pulse_clr();
		@(negedge clk);
		clr = 1;
		repeat (4) @(negedge clk);
		clr = 0;
	endtask : pulse_clr
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : tally_and_finish
	// Watchdog well beyond the longest expected run
	initial begin
		#1000000;
		failures++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		clr = 1;
		repeat (8) @(negedge clk);
		resetn = 1;
		clr = 0;
		@(negedge clk);
		check(16'(inReady), 16'h0000);
		reg_rd(`POP_ADDR_CTRL, rd);
		check(rd, 16'h0000);
		done("reset");
		foreach (rows[i]) begin
			reg_wr(rows[i].a, rows[i].w);
			reg_rd(rows[i].a, rd);
			check(rd, rows[i].e);
		end
		done("registers");
		reg_wr(`POP_ADDR_TIMING, 16'h1234);
		repeat (6) @(negedge clk);
		check(16'(laneDelayCode), 16'h0000);
		dllLocked = 1;
		repeat (6) @(negedge clk);
		check(16'(laneDelayCode), 16'h1234);
		reg_rd(`POP_ADDR_CTRL, rd);
		check(16'(rd[`POP_CTRL_STAT_LOCK]), 16'h0001);
		done("delay");
		foreach (pix[i]) begin
			reg_wr(`POP_ADDR_CTRL, pix[i].a);
			send_pix(pix[i].w);
			repeat (3) @(negedge clk);
			check(16'(rxWord), pix[i].e);
		end
		check(16'(rxCount), 16'h0009);
		check(16'(frame_qual_out), 16'h0001);
		done("parallel");
		reg_wr(`POP_ADDR_CTRL, 16'h006a);
		pulse_clr();
		repeat (40) @(negedge clk);
		check(16'(laneOn), 16'h0000);
		check(16'(clkLaneOn), 16'h0001);
		check(16'({pixClkOut, frame_qual_out, row_qual_out}), 16'h0000);
		send_pix(16'h0abc);
		repeat (12) @(negedge clk);
		check(serWord, 16'h0abc);
		done("active only");
		reg_wr(`POP_ADDR_CTRL, 16'h0066);
		pulse_clr();
		for (int n = 0; n < 20000 && markCount < 8'd3; n++) @(negedge clk);
		check(lineGap, 16'd4400);
		reg_wr(`POP_ADDR_TIMING, 16'h0000);
		done("continuous");
		resetn = 0;
		repeat (8) @(negedge clk);
		resetn = 1;
		reg_rd(`POP_ADDR_CTRL, rd);
		check(rd, 16'h0000);
		done("second reset");
		tally_and_finish();
	end
endmodule : tb_top
